// ---- hw/tpsc_ctrl.v ----
// Two-phase actuated signal sequencer with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "tpsc_regs.vh"

// Contract
// - Cycle six intervals: AG, AY, all red, BG, BY, all red, repeat.
// - Interval one, highway green, is rest; stay while no cross demand.
// - Fixed-time mode times every interval from presets, ignoring demand.
// - Fixed-time mode picks one of two timing sets by time of day.
// - Fixed-time mode runs pedestrian walks automatically with vehicle greens.
// - Semi-actuated mode answers demand only from the cross street.
// - Semi-actuated highway keeps green for guaranteed time and while no call.
// - Cross vehicle call moves through yellow and all red to cross green.
// - Cross green lasts at least the configured minimum.
// - Without further detection, advance through cross yellow, all red, rest.
// - Each rest re-entry holds guaranteed green before acting on calls.
// - No call at guaranteed green expiry keeps the highway green.
// - Detections after minimum extend cross green, never past maximum.
// - Extension ends on gap expiry or maximum green reached.
// - At maximum, stop cross traffic, return to rest, restart guaranteed green.
// - Semi mode: fixed highway green, cross green between minimum and maximum.
// - Walk across secondary street may show during highway green rest.
// - Push-button raises a call served like a cross vehicle call.
// - Pedestrian service uses its own, normally longer, programmed times.
// - Fully-actuated rests in highway green until other phase demand.
// - Fully-actuated gives each phase its own minimum and maximum green.
// - Fully-actuated returns to rest after cross demands are served.
// - Fully-actuated highway walks run only on push-button and start with highway green.
// - Same colour sequence for vehicle and pedestrian changes.
module tpsc_ctrl #(
   parameter [31:0] TICK_CYC = `TPSC_TICK_MS * `TPSC_CLK_KHZ
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Detectors and push-buttons
   input wire det_a,
   input wire det_b,
   input wire ped_btn_a,
   input wire ped_btn_b,
   // Lamp drivers
   output reg lamp_a_grn,
   output reg lamp_a_yel,
   output reg lamp_a_red,
   output reg lamp_b_grn,
   output reg lamp_b_yel,
   output reg lamp_b_red,
   output reg walk_a,
   output reg walk_b
);

   localparam ST_AG = 3'h0;
   localparam ST_AY = 3'h1;
   localparam ST_AR = 3'h2;
   localparam ST_BG = 3'h3;
   localparam ST_BY = 3'h4;
   localparam ST_BR = 3'h5;

   // Selects the low or high half of a timing word
   function [15:0] fld;
      input [31:0] w;
      input hi;
      begin
         fld = hi ? w[`TPSC_F_HI] : w[`TPSC_F_LO];
      end
   endfunction

   reg [1:0] mode;
   reg [16:0] tod;
   reg [16:0] tod_on;
   reg [16:0] tod_off;
   reg [31:0] fix0;
   reg [31:0] fix1;
   reg [31:0] clr_t;
   reg [31:0] agrn;
   reg [31:0] bgrn;
   reg [31:0] gap_t;
   reg [31:0] peda_t;
   reg dp_act;
   reg dp_wr;
   reg [7:0] dp_addr;
   reg rd_done;
   reg [31:0] rd_mux;
   reg [31:0] div_cnt;
   reg [3:0] sec_cnt;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [15:0] tmr;
   reg [15:0] gtmr;
   reg call_bv;
   reg call_bp;
   reg call_ap;
   reg served_a;
   reg served_b;

   wire wr;
   wire tick;
   wire sec;
   wire fixed;
   wire semi;
   wire full;
   wire set1;
   wire [31:0] fix_act;
   wire b_call;
   wire gap_done;
   wire a_ped_ok;
   wire b_ped_ok;
   wire enter_ag;
   wire enter_bg;
   wire leave_ag;
   wire leave_bg;
   wire det_cur;

   // Bus slave: writes take no wait state, reads take one
   assign wr = dp_act & dp_wr;
   assign hreadyout = ~(dp_act & ~dp_wr & ~rd_done);
   assign hresp = 1'b0;

   always @(posedge core_clk) begin
      if (srst) begin
         dp_act <= 1'b0;
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
      end else if (hready) begin
         dp_act <= hsel & htrans[1];
         dp_wr <= hwrite;
         dp_addr <= haddr[7:0];
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         rd_done <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         rd_done <= dp_act & ~dp_wr & ~rd_done;
         if (dp_act & ~dp_wr & ~rd_done) begin
            hrdata <= rd_mux;
         end
      end
   end

   always @* begin
      case (dp_addr)
         `TPSC_A_CTRL: rd_mux = {30'h0, mode};
         `TPSC_A_STATUS: rd_mux = {23'h0, served_b, served_a, call_ap,
            call_bp, call_bv, set1, state};
         `TPSC_A_TOD: rd_mux = {15'h0, tod};
         `TPSC_A_TODON: rd_mux = {15'h0, tod_on};
         `TPSC_A_TODOFF: rd_mux = {15'h0, tod_off};
         `TPSC_A_FIX0: rd_mux = fix0;
         `TPSC_A_FIX1: rd_mux = fix1;
         `TPSC_A_CLR: rd_mux = clr_t;
         `TPSC_A_AGRN: rd_mux = agrn;
         `TPSC_A_BGRN: rd_mux = bgrn;
         `TPSC_A_GAP: rd_mux = gap_t;
         `TPSC_A_PEDA: rd_mux = peda_t;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Configuration registers
   always @(posedge core_clk) begin
      if (srst) begin
         mode <= `TPSC_RST_MODE;
         tod_on <= `TPSC_RST_TODON;
         tod_off <= `TPSC_RST_TODOFF;
         fix0 <= `TPSC_RST_FIX;
         fix1 <= `TPSC_RST_FIX;
         clr_t <= `TPSC_RST_CLR;
         agrn <= `TPSC_RST_AGRN;
         bgrn <= `TPSC_RST_BGRN;
         gap_t <= `TPSC_RST_GAP;
         peda_t <= `TPSC_RST_PEDA;
      end else if (wr) begin
         case (dp_addr)
            `TPSC_A_CTRL: mode <= hwdata[`TPSC_F_MODE];
            `TPSC_A_TODON: tod_on <= hwdata[`TPSC_F_TOD];
            `TPSC_A_TODOFF: tod_off <= hwdata[`TPSC_F_TOD];
            `TPSC_A_FIX0: fix0 <= hwdata;
            `TPSC_A_FIX1: fix1 <= hwdata;
            `TPSC_A_CLR: clr_t <= hwdata;
            `TPSC_A_AGRN: agrn <= hwdata;
            `TPSC_A_BGRN: bgrn <= hwdata;
            `TPSC_A_GAP: gap_t <= hwdata;
            `TPSC_A_PEDA: peda_t <= hwdata;
            default: mode <= mode;
         endcase
      end
   end

   // Common time base: 100 ms tick and time of day in seconds
   assign tick = (div_cnt == TICK_CYC - 32'h1);
   assign sec = tick & (sec_cnt == `TPSC_TICKS_PER_S);

   always @(posedge core_clk) begin
      if (srst) begin
         div_cnt <= 32'h0;
         sec_cnt <= 4'h0;
      end else begin
         div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
         if (sec) begin
            sec_cnt <= 4'h0;
         end else if (tick) begin
            sec_cnt <= sec_cnt + 4'h1;
         end
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         tod <= 17'h0;
      end else if (wr && dp_addr == `TPSC_A_TOD) begin
         tod <= hwdata[`TPSC_F_TOD];
      end else if (sec) begin
         tod <= (tod == `TPSC_DAY_LAST) ? 17'h0 : tod + 17'h1;
      end
   end

   // Second timing set is active inside the window, which may wrap midnight
   assign set1 = (tod_on <= tod_off) ?
      (tod >= tod_on && tod < tod_off) :
      (tod >= tod_on || tod < tod_off);
   assign fix_act = set1 ? fix1 : fix0;

   assign fixed = (mode == `TPSC_MODE_FIXED);
   assign semi = (mode == `TPSC_MODE_SEMI);
   assign full = ~fixed & ~semi;

   // Only cross-street demand moves the rest interval in semi mode
   assign b_call = ~fixed & (call_bv | call_bp);
   assign det_cur = (state == ST_BG) ? det_b : det_a;
   assign gap_done = (gtmr >= fld(gap_t, 1'b0));
   assign a_ped_ok = ~served_a | (tmr >= fld(peda_t, 1'b0));
   assign b_ped_ok = ~served_b | (tmr >= fld(gap_t, 1'b1));

   // Highway green: fixed time, guaranteed then call, or actuated limits
   assign leave_ag = fixed ? (tmr >= fld(fix_act, 1'b0)) :
      b_call && tmr >= fld(agrn, 1'b0) &&
      (semi || (a_ped_ok && (gap_done ||
      tmr >= fld(agrn, 1'b1))));

   // Cross green: minimum, extended by gaps, cut at maximum
   assign leave_bg = fixed ? (tmr >= fld(fix_act, 1'b1)) :
      tmr >= fld(bgrn, 1'b0) && b_ped_ok &&
      (gap_done || tmr >= fld(bgrn, 1'b1));

   always @* begin
      next_state = state;
      case (state)
         ST_AG: if (leave_ag) next_state = ST_AY;
         ST_AY: if (tmr >= fld(clr_t, 1'b0)) next_state = ST_AR;
         ST_AR: if (tmr >= fld(clr_t, 1'b1)) next_state = ST_BG;
         ST_BG: if (leave_bg) next_state = ST_BY;
         ST_BY: if (tmr >= fld(clr_t, 1'b0)) next_state = ST_BR;
         ST_BR: if (tmr >= fld(clr_t, 1'b1)) next_state = ST_AG;
         default: next_state = ST_AG;
      endcase
   end

   assign enter_ag = (state != ST_AG) && (next_state == ST_AG);
   assign enter_bg = (state != ST_BG) && (next_state == ST_BG);

   // One sequence for all modes and demand types
   always @(posedge core_clk) begin
      if (srst) begin
         state <= ST_AG;
      end else begin
         state <= next_state;
      end
   end

   // Interval timer restarts on every entry, so guaranteed green reruns
   always @(posedge core_clk) begin
      if (srst) begin
         tmr <= 16'h0;
      end else if (next_state != state) begin
         tmr <= 16'h0;
      end else if (tick && tmr != `TPSC_SAT) begin
         tmr <= tmr + 16'h1;
      end
   end

   // Gap timer restarts on each detection of the phase holding green
   always @(posedge core_clk) begin
      if (srst) begin
         gtmr <= 16'h0;
      end else if (next_state != state || det_cur) begin
         gtmr <= 16'h0;
      end else if (tick && gtmr != `TPSC_SAT) begin
         gtmr <= gtmr + 16'h1;
      end
   end

   // Call latches: a new call in the clearing cycle survives
   always @(posedge core_clk) begin
      if (srst) begin
         call_bv <= 1'b0;
         call_bp <= 1'b0;
         call_ap <= 1'b0;
      end else begin
         call_bv <= (call_bv & ~enter_bg) |
            (det_b & ~fixed & state != ST_BG);
         call_bp <= (call_bp & ~enter_bg) | (ped_btn_b & ~fixed);
         call_ap <= (call_ap & ~enter_ag) | (ped_btn_a & full);
      end
   end

   // Pedestrian service taken at the start of the serving green
   always @(posedge core_clk) begin
      if (srst) begin
         served_a <= 1'b0;
         served_b <= 1'b0;
      end else begin
         if (enter_ag) begin
            served_a <= full & (call_ap | ped_btn_a);
         end
         if (enter_bg) begin
            served_b <= fixed | call_bp | (ped_btn_b & ~fixed);
         end
      end
   end

   // Lamp and walk drivers follow the interval one cycle later
   always @(posedge core_clk) begin
      if (srst) begin
         lamp_a_grn <= 1'b1;
         lamp_a_yel <= 1'b0;
         lamp_a_red <= 1'b0;
         lamp_b_grn <= 1'b0;
         lamp_b_yel <= 1'b0;
         lamp_b_red <= 1'b1;
         walk_a <= 1'b0;
         walk_b <= 1'b0;
      end else begin
         lamp_a_grn <= (state == ST_AG);
         lamp_a_yel <= (state == ST_AY);
         lamp_a_red <= (state != ST_AG) && (state != ST_AY);
         lamp_b_grn <= (state == ST_BG);
         lamp_b_yel <= (state == ST_BY);
         lamp_b_red <= (state != ST_BG) && (state != ST_BY);
         walk_a <= (state == ST_AG) &&
            (~full | (served_a & ~a_ped_ok));
         walk_b <= (state == ST_BG) && served_b && ~b_ped_ok;
      end
   end

endmodule // tpsc_ctrl

`default_nettype wire

// ---- hw/tpsc_regs.vh ----
// Register map, field layout, reset values and timing constants
`ifndef TPSC_REGS_VH
`define TPSC_REGS_VH

// Byte offsets on the register bus
`define TPSC_A_CTRL 8'h00
`define TPSC_A_STATUS 8'h04
`define TPSC_A_TOD 8'h08
`define TPSC_A_TODON 8'h0C
`define TPSC_A_TODOFF 8'h10
`define TPSC_A_FIX0 8'h14
`define TPSC_A_FIX1 8'h18
`define TPSC_A_CLR 8'h1C
`define TPSC_A_AGRN 8'h20
`define TPSC_A_BGRN 8'h24
`define TPSC_A_GAP 8'h28
`define TPSC_A_PEDA 8'h2C

// Field positions
`define TPSC_F_MODE 1:0
`define TPSC_F_TOD 16:0
`define TPSC_F_LO 15:0
`define TPSC_F_HI 31:16

// Operating modes
`define TPSC_MODE_FIXED 2'h0
`define TPSC_MODE_SEMI 2'h1
`define TPSC_MODE_FULL 2'h2

// Reset values, times in 100 ms units, time of day in seconds
`define TPSC_RST_MODE 2'h1
`define TPSC_RST_TODON 17'h06270
`define TPSC_RST_TODOFF 17'h10B30
`define TPSC_RST_FIX 32'h00C8_012C
`define TPSC_RST_CLR 32'h0014_001E
`define TPSC_RST_AGRN 32'h0258_00C8
`define TPSC_RST_BGRN 32'h012C_0046
`define TPSC_RST_GAP 32'h0096_001E
`define TPSC_RST_PEDA 32'h0000_0096

// Time base
`define TPSC_TICK_MS 32'h0000_0064
`define TPSC_CLK_KHZ 32'h0003_D090
`define TPSC_TICKS_PER_S 4'h9
`define TPSC_DAY_LAST 17'h1517F
`define TPSC_SAT 16'hFFFF

`endif

// ---- verification/tpsc_ctrl_checker.sv ----
// Port-level assertions for the signal sequencer
`timescale 1ns/10ps
`default_nettype none
module tpsc_ctrl_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Lamps and walks
   input wire logic lamp_a_grn,
   input wire logic lamp_a_yel,
   input wire logic lamp_a_red,
   input wire logic lamp_b_grn,
   input wire logic lamp_b_yel,
   input wire logic lamp_b_red,
   input wire logic walk_a,
   input wire logic walk_b
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_a_onehot: assert property (
      $onehot({lamp_a_grn, lamp_a_yel, lamp_a_red}))
      else $error("highway head not one colour");
   a_b_onehot: assert property (
      $onehot({lamp_b_grn, lamp_b_yel, lamp_b_red}))
      else $error("cross head not one colour");
   a_no_conflict: assert property (lamp_a_red || lamp_b_red)
      else $error("both heads released");
   a_a_grn_exit: assert property ($fell(lamp_a_grn) |-> lamp_a_yel)
      else $error("highway green not followed by yellow");
   a_a_yel_exit: assert property ($fell(lamp_a_yel) |->
      lamp_b_red && lamp_a_red) else $error("highway yellow not to all red");
   a_b_grn_entry: assert property ($rose(lamp_b_grn) |->
      $past(lamp_a_red) && $past(lamp_b_red))
      else $error("cross green without all red");
   a_b_grn_exit: assert property ($fell(lamp_b_grn) |-> lamp_b_yel)
      else $error("cross green not followed by yellow");
   a_b_yel_exit: assert property ($fell(lamp_b_yel) |->
      lamp_a_red ##1 lamp_b_red) else $error("cross yellow not to all red");
   a_walk_cross: assert property (walk_b |-> lamp_a_red)
      else $error("highway walk while highway moves");
   a_walk_hwy: assert property (walk_a |-> lamp_b_red)
      else $error("side walk while cross moves");
   a_rd_wait: assert property (
      hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
   a_wr_nowait: assert property (
      hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write wait wrong");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response");
   a_reset_rest: assert property (disable iff (1'b0) srst |=>
      lamp_a_grn && lamp_b_red && !walk_b) else $error("reset not at rest");
endmodule // tpsc_ctrl_checker
`default_nettype wire

// ---- verification/tpsc_ctrl_test.sv ----
// Self-checking bench for the two-phase signal sequencer
`timescale 1ns/10ps
`default_nettype none
module tpsc_ctrl_test;
   localparam int T = 4;
   localparam logic [5:0] AG = 6'h21, AY = 6'h11, BG = 6'h0C, BY = 6'h0A;
   logic core_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
   logic wa, wb;
   wire [31:0] hrdata;
   wire hreadyout, hresp, det_a, det_b, ped_btn_a, ped_btn_b, walk_a, walk_b;
   wire lamp_a_grn, lamp_a_yel, lamp_a_red, lamp_b_grn, lamp_b_yel, lamp_b_red;
   wire [5:0] lamps = {lamp_a_grn, lamp_a_yel, lamp_a_red,
      lamp_b_grn, lamp_b_yel, lamp_b_red};
   int err_total = 0, compares = 0, cyc = 0, n;
   always #2 core_clk = ~core_clk;
   tpsc_ctrl #(.TICK_CYC(32'd4)) dut (.core_clk(core_clk), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .det_a(det_a), .det_b(det_b), .ped_btn_a(ped_btn_a),
      .ped_btn_b(ped_btn_b), .lamp_a_grn(lamp_a_grn),
      .lamp_a_yel(lamp_a_yel), .lamp_a_red(lamp_a_red),
      .lamp_b_grn(lamp_b_grn), .lamp_b_yel(lamp_b_yel),
      .lamp_b_red(lamp_b_red), .walk_a(walk_a), .walk_b(walk_b));
   tpsc_road road (.core_clk(core_clk), .det_a(det_a), .det_b(det_b),
      .ped_btn_a(ped_btn_a), .ped_btn_b(ped_btn_b));
   task test_done;
      if (err_total == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      haddr <= {24'h0, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task arrive(input logic [5:0] iv);
      while (lamps !== iv) @(posedge core_clk);
   endtask
   // Interval length must lie in (lo, hi] ticks
   task dur(input logic [5:0] iv, input int lo, input int hi, input string nm);
      arrive(iv);
      n = 0;
      wa = 1'b0;
      wb = 1'b0;
      while (lamps === iv) begin
         @(posedge core_clk);
         n++;
         wa |= walk_a;
         wb |= walk_b;
      end
      chk(nm, n > lo * T && n <= hi * T + 1, 1);
   endtask
   task settle;
      int k;
      k = 0;
      while (k < 80) begin
         @(posedge core_clk);
         k = (lamps === AG) ? k + 1 : 0;
      end
   endtask
   task t_reset;
      chk("reset lamps", lamps, AG);
      bus(0, 8'h00, 0);
      chk("mode", q, 32'h1);
      bus(0, 8'h1C, 0);
      chk("clearance", q, 32'h0014_001E);
      bus(1, 8'h04, 32'hFFFF_FFFF);
      bus(0, 8'h04, 0);
      chk("status", q & 32'h0000_01F7, 32'h0);
      bus(0, 8'h30, 0);
      chk("unmapped", q, 32'h0);
   endtask
   task t_cfg;
      bus(1, 8'h1C, 32'h0001_0002);
      bus(1, 8'h20, 32'h0010_0004);
      bus(1, 8'h24, 32'h000C_0003);
      bus(1, 8'h28, 32'h0005_0002);
      bus(1, 8'h2C, 32'h0000_0003);
      bus(0, 8'h24, 0);
      chk("cross limits", q, 32'h000C_0003);
   endtask
   task t_rest;
      settle;
      road.drive(4'hA);
      road.drive(4'h0);
      repeat (120) @(posedge core_clk);
      chk("rest hold", lamps, AG);
      chk("side walk", walk_a, 1);
      bus(0, 8'h04, 0);
      chk("highway calls", q & 32'h0000_0070, 32'h0);
   endtask
   task t_semi;
      settle;
      road.drive(4'h4);
      road.drive(4'h0);
      dur(AY, 1, 2, "yellow");
      dur(BG, 2, 3, "cross min");
      chk("no walk", wb, 0);
      dur(BY, 1, 2, "cross yellow");
      bus(0, 8'h04, 0);
      chk("calls cleared", q & 32'h0000_0030, 32'h0);
   endtask
   task t_max;
      settle;
      road.drive(4'h4);
      dur(BG, 11, 12, "max green");
      dur(AG, 3, 4, "guaranteed");
      road.drive(4'h0);
   endtask
   task t_ped;
      settle;
      road.drive(4'h1);
      road.drive(4'h0);
      dur(BG, 4, 5, "ped green");
      chk("cross walk", wb, 1);
   endtask
   task t_full;
      bus(1, 8'h00, 32'h2);
      settle;
      chk("full rest", lamps, AG);
      chk("no side walk", walk_a, 0);
      road.drive(4'hE);
      road.drive(4'h8);
      arrive(BY);
      road.drive(4'hC);
      road.drive(4'h8);
      dur(AG, 15, 16, "highway max");
      chk("side walk", wa, 1);
      road.drive(4'h0);
   endtask
   task t_fixed;
      bus(1, 8'h14, 32'h0005_0003);
      bus(1, 8'h18, 32'h0002_0006);
      bus(1, 8'h08, 32'h0);
      bus(1, 8'h00, 32'h0);
      road.drive(4'h4);
      arrive(AG);
      dur(BG, 4, 5, "fixed cross");
      chk("auto walk", wb, 1);
      bus(1, 8'h08, 32'h0000_7530);
      bus(0, 8'h04, 0);
      chk("day set", q[3], 1);
      arrive(AG);
      dur(BG, 1, 2, "second set");
      road.drive(4'h0);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      t_reset;
      t_cfg;
      t_rest;
      t_semi;
      t_max;
      t_ped;
      t_full;
      t_fixed;
      test_done;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         test_done;
      end
   end
endmodule // tpsc_ctrl_test
bind tpsc_ctrl tpsc_ctrl_checker chk_i (.core_clk(core_clk), .srst(srst),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .lamp_a_grn(lamp_a_grn),
   .lamp_a_yel(lamp_a_yel), .lamp_a_red(lamp_a_red),
   .lamp_b_grn(lamp_b_grn), .lamp_b_yel(lamp_b_yel),
   .lamp_b_red(lamp_b_red), .walk_a(walk_a), .walk_b(walk_b));
`default_nettype wire

// ---- verification/tpsc_road.sv ----
// Street-side model: vehicle detectors and push-buttons
`timescale 1ns/10ps
`default_nettype none
module tpsc_road (
   // Clock
   input wire logic core_clk,
   // Detectors and push-buttons
   output logic det_a,
   output logic det_b,
   output logic ped_btn_a,
   output logic ped_btn_b
);
   initial begin
      {det_a, det_b, ped_btn_a, ped_btn_b} = 4'h0;
   end
   // Levels change only just after a clock edge
   task drive(input logic [3:0] m);
      @(posedge core_clk);
      {det_a, det_b, ped_btn_a, ped_btn_b} <= m;
   endtask
endmodule // tpsc_road
`default_nettype wire
